// *** dhos_head_ctrl.sv ***
// Head offset, return to centerline and sector search sequencer
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module dhos_head_ctrl import dhos_pkg::*; #(
  parameter int unsigned RTC_CYCLES = DHOS_RTC_CYCLES,
  parameter int unsigned SEEK_CYCLES = DHOS_SEEK_CYCLES,
  parameter int unsigned RECAL_CYCLES = DHOS_RECAL_CYCLES
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic reset_n, // Synchronous reset
  input wire logic [DHOS_AW-1:0] addr, // Register index
  input wire logic [DHOS_DW-1:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [DHOS_DW-1:0] rd_data, // Read data, cycle after strobe
  input wire logic pos_done_pin, // Positioner settled
  input wire logic pos_fault_pin, // Positioner error
  input wire logic xfer_done_pin, // Read or write finished
  input wire logic index_pin, // Index pulse
  input wire logic [DHOS_SEC_W-1:0] sector_count_pin, // Rotating sector counter
  output logic pos_go, // One-cycle move request
  output dhos_pos_cmd_t pos_cmd, // Move kind and target
  output logic xfer_go, // One-cycle transfer request
  output dhos_xfer_t xfer_cmd, // Transfer target
  output logic attention_line, // Attention to controller
  output logic drive_ready_flag, // Drive ready
  output logic positioning_active // Positioning in progress
);
  if (RTC_CYCLES < 1 || SEEK_CYCLES < 1 || RECAL_CYCLES < 1 ||
      RECAL_CYCLES >= (64'd1 << DHOS_TMR_W) || SEEK_CYCLES >= (64'd1 << DHOS_TMR_W) ||
      RTC_CYCLES >= (64'd1 << DHOS_TMR_W)) begin : g_bad_time
    $error("dhos_head_ctrl: timeout counts out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_MOVE, ST_WAIT, ST_XFER, ST_SEARCH, ST_FIN} dhos_state_t;

  localparam int SW = 4 + DHOS_SEC_W;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [3:0] sync3;
  logic pos_done_rise;
  logic pos_fault;
  logic xfer_done_rise;
  logic index_rise;
  logic [DHOS_SEC_W-1:0] sector_now;

  dhos_state_t state;
  logic [5:0] cmd_fn;
  logic cmd_pend;
  dhos_kind_t kind;
  logic auto_rtc;
  logic clear_off;
  logic heads_offset;
  logic [DHOS_CYL_W-1:0] cur_cyl;
  logic [1:0] fin_step;
  logic fin_attention_line;
  logic [1:0] idx_cnt;
  logic set_attention_line;
  logic set_ski;
  logic set_opi;
  logic off_clear;
  logic tmr_load;
  logic tmr_stop;
  logic [DHOS_TMR_W-1:0] tmr_count;
  logic tmr_expired;
  logic [1:0] err_flags;

  logic [DHOS_OFF_SIGN:0] offset_reg;
  logic [DHOS_SEC_W-1:0] sector_reg;
  logic [DHOS_TRK_W-1:0] track_reg;
  logic [DHOS_CYL_W-1:0] cyl_reg;

  logic go_move;
  logic go_auto;
  logic go_xfer;
  logic go_search;
  dhos_kind_t go_kind;
  logic cyl_differs;
  logic sw_wr_status;
  logic [DHOS_TMR_W-1:0] next_tmr_count;

  // Pins cross in through two flops; edges compare the second stage with a third flop
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {sector_count_pin, index_pin, xfer_done_pin, pos_fault_pin, pos_done_pin};
      sync2 <= sync1;
      sync3 <= sync2[3:0];
    end
  end

  // Sector counter is sampled bit by bit; the match test sees a stable code
  // only because the counter holds each value for a whole sector time.
  assign pos_done_rise = sync2[0] & ~sync3[0];
  // Fault taken on its rise; a level still in the chain would abort the recalibrate
  assign pos_fault = sync2[1] & ~sync3[1];
  assign xfer_done_rise = sync2[2] & ~sync3[2];
  assign index_rise = sync2[3] & ~sync3[3];
  assign sector_now = sync2[SW-1:4];
  assign cyl_differs = (cyl_reg != cur_cyl);
  assign sw_wr_status = wr_en && (addr == DHOS_REG_STATUS);

  // Dispatch: a pending command either moves the heads, transfers or searches; any other code is dropped.
  // After an automatic return the same command is dispatched again.
  always_comb begin
    go_move = 1'b0;
    go_auto = 1'b0;
    go_xfer = 1'b0;
    go_search = 1'b0;
    go_kind = DHOS_K_RTC;
    unique case (cmd_fn)
      DHOS_FN_OFFSET: begin
        go_move = 1'b1;
        go_kind = DHOS_K_OFFSET;
      end
      DHOS_FN_RTC: begin
        go_move = 1'b1;
      end
      DHOS_FN_SEEK, DHOS_FN_RECAL: begin
        go_move = 1'b1;
        go_auto = heads_offset;
        if (!heads_offset) begin
          go_kind = (cmd_fn == DHOS_FN_SEEK) ? DHOS_K_SEEK : DHOS_K_RECAL;
        end
      end
      DHOS_FN_READ: begin
        if (cyl_differs) begin
          go_move = 1'b1;
          go_auto = heads_offset;
          if (!heads_offset) begin
            go_kind = DHOS_K_SEEK;
          end
        end else begin
          go_xfer = 1'b1;
        end
      end
      DHOS_FN_WRITE: begin
        if (heads_offset || cyl_differs) begin
          go_move = 1'b1;
          go_auto = heads_offset;
          if (!heads_offset) begin
            go_kind = DHOS_K_SEEK;
          end
        end else begin
          go_xfer = 1'b1;
        end
      end
      DHOS_FN_SEARCH: begin
        go_search = 1'b1;
      end
      default: begin
        go_move = 1'b0;
      end
    endcase
  end

  always_comb begin
    unique case (kind)
      DHOS_K_SEEK: next_tmr_count = DHOS_TMR_W'(SEEK_CYCLES);
      DHOS_K_RECAL: next_tmr_count = DHOS_TMR_W'(RECAL_CYCLES);
      default: next_tmr_count = DHOS_TMR_W'(RTC_CYCLES);
    endcase
  end

  // Command sequencer
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cmd_fn <= '0;
      cmd_pend <= 1'b0;
      kind <= DHOS_K_RTC;
      auto_rtc <= 1'b0;
      clear_off <= 1'b0;
      heads_offset <= 1'b0;
      cur_cyl <= '0;
      fin_step <= '0;
      fin_attention_line <= 1'b0;
      idx_cnt <= '0;
      set_attention_line <= 1'b0;
      set_ski <= 1'b0;
      set_opi <= 1'b0;
      off_clear <= 1'b0;
      tmr_load <= 1'b0;
      tmr_stop <= 1'b0;
      tmr_count <= '0;
      pos_go <= 1'b0;
      pos_cmd <= '0;
      xfer_go <= 1'b0;
      xfer_cmd <= '0;
      drive_ready_flag <= 1'b1;
      positioning_active <= 1'b0;
    end else begin
      set_attention_line <= 1'b0;
      set_ski <= 1'b0;
      set_opi <= 1'b0;
      off_clear <= 1'b0;
      tmr_load <= 1'b0;
      tmr_stop <= 1'b0;
      pos_go <= 1'b0;
      xfer_go <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (cmd_pend) begin
            if (go_move) begin
              positioning_active <= 1'b1;
              drive_ready_flag <= 1'b0;
              kind <= go_kind;
              auto_rtc <= go_auto;
              if (go_auto) begin
                clear_off <= 1'b1;
              end
              state <= ST_MOVE;
            end else if (go_xfer) begin
              // Return before a write must not clear the offset code on a later seek
              clear_off <= 1'b0;
              drive_ready_flag <= 1'b0;
              xfer_go <= 1'b1;
              xfer_cmd <= '{write: (cmd_fn == DHOS_FN_WRITE), track: track_reg,
                            sector: sector_reg};
              state <= ST_XFER;
            end else if (go_search) begin
              drive_ready_flag <= 1'b0;
              idx_cnt <= '0;
              cmd_pend <= 1'b0;
              state <= ST_SEARCH;
            end else begin
              cmd_pend <= 1'b0;
            end
          end else if (wr_en && addr == DHOS_REG_CTRL && wr_data[DHOS_GO_BIT]) begin
            cmd_fn <= wr_data[5:0];
            cmd_pend <= 1'b1;
          end
        end
        ST_MOVE: begin
          pos_go <= 1'b1;
          // sign bit 7, bit 6 dropped
          pos_cmd <= '{kind: kind, cyl: cyl_reg,
                       off_sign: (kind == DHOS_K_OFFSET) & offset_reg[DHOS_OFF_SIGN],
                       off_mag: (kind == DHOS_K_OFFSET) ? offset_reg[DHOS_OFF_MAG_HI:0] : '0};
          tmr_load <= 1'b1;
          tmr_count <= next_tmr_count;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (pos_fault || tmr_expired) begin
            tmr_stop <= 1'b1;
            set_ski <= 1'b1;
            cmd_pend <= 1'b0;
            clear_off <= 1'b0;
            if (kind == DHOS_K_RECAL) begin
              fin_attention_line <= 1'b1;
              fin_step <= '0;
              state <= ST_FIN;
            end else begin
              kind <= DHOS_K_RECAL;
              auto_rtc <= 1'b0;
              state <= ST_MOVE;
            end
          end else if (pos_done_rise) begin
            tmr_stop <= 1'b1;
            fin_step <= '0;
            unique case (kind)
              DHOS_K_OFFSET: begin
                heads_offset <= |offset_reg[DHOS_OFF_MAG_HI:0];
                cmd_pend <= 1'b0;
                fin_attention_line <= 1'b1;
                state <= ST_FIN;
              end
              DHOS_K_RTC: begin
                heads_offset <= 1'b0;
                if (auto_rtc) begin
                  state <= ST_IDLE;
                end else begin
                  cmd_pend <= 1'b0;
                  fin_attention_line <= 1'b1;
                  state <= ST_FIN;
                end
              end
              DHOS_K_SEEK: begin
                cur_cyl <= cyl_reg;
                if (clear_off) begin
                  off_clear <= 1'b1;
                  clear_off <= 1'b0;
                end
                if (cmd_fn == DHOS_FN_SEEK) begin
                  cmd_pend <= 1'b0;
                  fin_attention_line <= 1'b1;
                  state <= ST_FIN;
                end else begin
                  state <= ST_IDLE;
                end
              end
              DHOS_K_RECAL: begin
                cur_cyl <= '0;
                heads_offset <= 1'b0;
                off_clear <= 1'b1;
                clear_off <= 1'b0;
                cmd_pend <= 1'b0;
                fin_attention_line <= 1'b1;
                state <= ST_FIN;
              end
            endcase
          end
        end
        ST_XFER: begin
          if (xfer_done_rise) begin
            cmd_pend <= 1'b0;
            fin_attention_line <= 1'b0;
            fin_step <= '0;
            state <= ST_FIN;
          end
        end
        ST_SEARCH: begin
          fin_step <= '0;
          if (sector_now == sector_reg) begin
            fin_attention_line <= 1'b1;
            state <= ST_FIN;
          end else if (index_rise) begin
            if (idx_cnt == DHOS_INDEX_LIMIT - 2'h1) begin
              set_opi <= 1'b1;
              fin_attention_line <= 1'b0;
              state <= ST_FIN;
            end else begin
              idx_cnt <= idx_cnt + 2'h1;
            end
          end
        end
        ST_FIN: begin
          // active off, ready on, attention last
          fin_step <= fin_step + 2'h1;
          if (fin_step == 2'h0) begin
            positioning_active <= 1'b0;
          end else if (fin_step == 2'h1) begin
            drive_ready_flag <= 1'b1;
          end else begin
            set_attention_line <= fin_attention_line;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  dhos_timer #(
    .TW(DHOS_TMR_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(tmr_load),
    .count(tmr_count),
    .stop(tmr_stop),
    .expired(tmr_expired)
  );

  // Sticky flags, write one to clear; a set in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      attention_line <= 1'b0;
      err_flags <= '0;
    end else begin
      attention_line <= set_attention_line |
        (attention_line & ~(sw_wr_status & wr_data[DHOS_ST_ATTENTION_LINE]));
      err_flags <= {set_opi, set_ski} |
        (err_flags & ~(sw_wr_status ? wr_data[DHOS_ST_OP_INC:DHOS_ST_SEEK_INC] : 2'h0));
    end
  end

  // Software registers; hardware clear of the offset code wins over a write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      offset_reg <= '0;
      sector_reg <= '0;
      track_reg <= '0;
      cyl_reg <= '0;
    end else begin
      if (off_clear) begin
        offset_reg <= '0;
      end else if (wr_en && addr == DHOS_REG_OFFSET) begin
        offset_reg <= {wr_data[DHOS_OFF_SIGN], 1'b0, wr_data[DHOS_OFF_MAG_HI:0]};
      end
      if (wr_en && addr == DHOS_REG_SECTRK) begin
        sector_reg <= wr_data[DHOS_SEC_LO +: DHOS_SEC_W];
        track_reg <= wr_data[DHOS_TRK_LO +: DHOS_TRK_W];
      end
      if (wr_en && addr == DHOS_REG_CYL) begin
        cyl_reg <= wr_data[DHOS_CYL_W-1:0];
      end
    end
  end

  // Read port; unmapped indices read zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= '0;
      unique case (addr)
        DHOS_REG_CTRL: rd_data[5:0] <= cmd_fn;
        DHOS_REG_STATUS: begin
          rd_data[DHOS_ST_ATTENTION_LINE] <= attention_line;
          rd_data[DHOS_ST_OP_INC:DHOS_ST_SEEK_INC] <= err_flags;
          rd_data[DHOS_ST_READY] <= drive_ready_flag;
          rd_data[DHOS_ST_ACTIVE] <= positioning_active;
          rd_data[DHOS_ST_OFFSET] <= heads_offset;
        end
        DHOS_REG_OFFSET: rd_data[DHOS_OFF_SIGN:0] <= offset_reg;
        DHOS_REG_SECTRK: begin
          rd_data[DHOS_SEC_LO +: DHOS_SEC_W] <= sector_reg;
          rd_data[DHOS_TRK_LO +: DHOS_TRK_W] <= track_reg;
        end
        DHOS_REG_CYL: rd_data[DHOS_CYL_W-1:0] <= cyl_reg;
        DHOS_REG_CURCYL: rd_data[DHOS_CYL_W-1:0] <= cur_cyl;
        default: rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end
endmodule : dhos_head_ctrl

// *** dhos_pkg.sv ***
// Constants, carriers and register map of the head offset and search logic
// Functional notes
// - Offset command 15 octal takes displacement and direction from offset register.
// - Offset start sets positioning active and clears drive ready before motion.
// - Offset done: clear positioning active, set ready, then set attention.
// - Offset code: bit 7 sign, bit 6 unused, bits 5..0 weigh 800..25 uin.
// - A read while offset leaves heads at the offset position.
// - Seek to another cylinder while offset returns to centerline first.
// - Seek preceded by automatic return clears offset register on completion.
// - Read to another track on same cylinder runs at existing offset.
// - Never write while offset; auto return to centerline, then write.
// - Incomplete offset sets seek incomplete and starts automatic recalibrate.
// - Return command 17 octal reaches centerline within 10 ms, then attention.
// - Seek or recalibrate while offset performs automatic return first.
// - Automatic return to centerline never raises attention.
// - Positioning error during return sets seek incomplete, then recalibrates.
// - Search 31 octal compares sector counter to desired sector, attention on match.
// - Attention flags sector match only for search, not read or write.
// - No match within two index pulses sets operation incomplete.
package dhos_pkg;
  localparam int unsigned DHOS_CLK_HZ = 100_000_000;
  localparam int unsigned DHOS_RTC_TIME_MS = 10;
  localparam int unsigned DHOS_SEEK_TIME_MS = 50;
  localparam int unsigned DHOS_RECAL_TIME_MS = 500;
  localparam int unsigned DHOS_CYC_PER_MS = DHOS_CLK_HZ / 1000;
  localparam int unsigned DHOS_RTC_CYCLES = DHOS_RTC_TIME_MS * DHOS_CYC_PER_MS;
  localparam int unsigned DHOS_SEEK_CYCLES = DHOS_SEEK_TIME_MS * DHOS_CYC_PER_MS;
  localparam int unsigned DHOS_RECAL_CYCLES = DHOS_RECAL_TIME_MS * DHOS_CYC_PER_MS;
  localparam int DHOS_TMR_W = 26;
  localparam int DHOS_AW = 3;
  localparam int DHOS_DW = 16;
  localparam int DHOS_CYL_W = 10;
  localparam int DHOS_SEC_W = 5;
  localparam int DHOS_TRK_W = 5;
  // Register indices
  localparam logic [2:0] DHOS_REG_CTRL = 3'h0;
  localparam logic [2:0] DHOS_REG_STATUS = 3'h1;
  localparam logic [2:0] DHOS_REG_OFFSET = 3'h2;
  localparam logic [2:0] DHOS_REG_SECTRK = 3'h3;
  localparam logic [2:0] DHOS_REG_CYL = 3'h4;
  localparam logic [2:0] DHOS_REG_CURCYL = 3'h5;
  // Function codes, go bit included as bit 0
  localparam logic [5:0] DHOS_FN_SEEK = 6'h05;
  localparam logic [5:0] DHOS_FN_RECAL = 6'h07;
  localparam logic [5:0] DHOS_FN_OFFSET = 6'h0d;
  localparam logic [5:0] DHOS_FN_RTC = 6'h0f;
  localparam logic [5:0] DHOS_FN_SEARCH = 6'h19;
  localparam logic [5:0] DHOS_FN_WRITE = 6'h31;
  localparam logic [5:0] DHOS_FN_READ = 6'h39;
  localparam int DHOS_GO_BIT = 0;
  // Status bit positions
  localparam int DHOS_ST_ATTENTION_LINE = 0;
  localparam int DHOS_ST_SEEK_INC = 1;
  localparam int DHOS_ST_OP_INC = 2;
  localparam int DHOS_ST_READY = 3;
  localparam int DHOS_ST_ACTIVE = 4;
  localparam int DHOS_ST_OFFSET = 5;
  // Offset code and sector/track fields
  localparam int DHOS_OFF_SIGN = 7;
  localparam int DHOS_OFF_MAG_HI = 5;
  localparam int DHOS_SEC_LO = 0;
  localparam int DHOS_TRK_LO = 8;
  localparam logic [1:0] DHOS_INDEX_LIMIT = 2'h2;
  typedef enum logic [1:0] {DHOS_K_OFFSET, DHOS_K_RTC, DHOS_K_SEEK, DHOS_K_RECAL} dhos_kind_t;
  typedef struct packed {
    dhos_kind_t kind;
    logic [DHOS_CYL_W-1:0] cyl;
    logic off_sign;
    logic [DHOS_OFF_MAG_HI:0] off_mag;
  } dhos_pos_cmd_t;
  typedef struct packed {
    logic write;
    logic [DHOS_TRK_W-1:0] track;
    logic [DHOS_SEC_W-1:0] sector;
  } dhos_xfer_t;
endpackage : dhos_pkg

// *** dhos_timer.sv ***
// Loadable down counter that flags a positioner move running too long
`timescale 1ns/10ps
module dhos_timer import dhos_pkg::*; #(
  parameter int TW = DHOS_TMR_W
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic load, // Start counting
  input wire logic [TW-1:0] count, // Cycles allowed
  input wire logic stop, // Abandon the count
  output logic expired // One-cycle timeout pulse
);
  logic [TW-1:0] remain;
  logic running;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      remain <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        remain <= count;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (remain <= TW'(1)) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          remain <= remain - TW'(1);
        end
      end
    end
  end
endmodule : dhos_timer

// *** dhos_head_ctrl_asserts.sv ***
// Port-level checks on the head offset and search sequencer
`timescale 1ns/10ps
module dhos_head_ctrl_asserts import dhos_pkg::*; #(
  parameter int unsigned RTC_CYCLES = DHOS_RTC_CYCLES,
  parameter int unsigned SEEK_CYCLES = DHOS_SEEK_CYCLES,
  parameter int unsigned RECAL_CYCLES = DHOS_RECAL_CYCLES
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic rd_en, // Read strobe
  input wire logic [DHOS_DW-1:0] rd_data, // Read data
  input wire logic pos_go, // Move request
  input wire dhos_pos_cmd_t pos_cmd, // Move target
  input wire logic xfer_go, // Transfer request
  input wire dhos_xfer_t xfer_cmd, // Transfer target
  input wire logic attention_line, // Attention
  input wire logic drive_ready_flag, // Ready
  input wire logic positioning_active // Busy moving
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_go_busy: assert property (pos_go |-> positioning_active && !drive_ready_flag)
    else $error("move issued without busy flags");
  a_busy_not_ready: assert property (positioning_active |-> !drive_ready_flag)
    else $error("ready while positioning");
  a_offset_done: assert property ($fell(positioning_active) ##1
    ($rose(drive_ready_flag) && pos_cmd.kind == DHOS_K_OFFSET) |-> ##2 attention_line)
    else $error("offset end order wrong");
  a_attention_line_settled: assert property ($rose(attention_line) |->
    drive_ready_flag && !positioning_active)
    else $error("attention before settle");
  a_write_centred: assert property (xfer_go && xfer_cmd.write |->
    pos_cmd.kind != DHOS_K_OFFSET || pos_cmd.off_mag == '0)
    else $error("write while offset");
  a_move_centred: assert property (pos_go && pos_cmd.kind != DHOS_K_OFFSET |->
    !pos_cmd.off_sign && pos_cmd.off_mag == '0)
    else $error("non-offset move carries offset");
  a_cmd_stands: assert property (!pos_go |-> $stable(pos_cmd))
    else $error("move target changed without request");
  a_xfer_silent: assert property (xfer_go && !attention_line |=>
    !attention_line [*8])
    else $error("transfer raised attention");
  a_rd_idle: assert property (!rd_en |=> rd_data == '0)
    else $error("read data outside read cycle");
  c_rtc: cover property (pos_go && pos_cmd.kind == DHOS_K_RTC);
  c_attention_line: cover property ($rose(attention_line));
  c_write: cover property (xfer_go && xfer_cmd.write);
endmodule : dhos_head_ctrl_asserts

bind dhos_head_ctrl dhos_head_ctrl_asserts #(.RTC_CYCLES(RTC_CYCLES),
  .SEEK_CYCLES(SEEK_CYCLES), .RECAL_CYCLES(RECAL_CYCLES)) u_chk (.sys_clk, .reset_n,
  .rd_en, .rd_data, .pos_go, .pos_cmd, .xfer_go, .xfer_cmd, .attention_line,
  .drive_ready_flag, .positioning_active);

// *** dhos_positioner_model.sv ***
// Positioner, transfer unit and spinning pack facing the sequencer
`timescale 1ns/10ps
module dhos_positioner_model import dhos_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic pos_go, // Move request
  input wire logic xfer_go, // Transfer request
  input wire logic fault_next, // Fail the next move
  input wire logic slow, // Long settle time
  output logic pos_done_pin, // Settled
  output logic pos_fault_pin, // Move failed
  output logic xfer_done_pin, // Transfer finished
  output logic index_pin, // Once a turn
  output logic [DHOS_SEC_W-1:0] sector_count_pin // Sector under heads
);
  logic [5:0] mv_t = '0;
  logic mv_bad = 1'b0;
  logic [4:0] xf_t = '0;
  logic [2:0] div = '0;
  logic [4:0] sec = '0;
  always_ff @(posedge sys_clk) begin
    if (pos_go) begin
      mv_t <= slow ? 6'h28 : 6'h0a;
      mv_bad <= fault_next;
    end else if (mv_t != 6'h0) begin
      mv_t <= mv_t - 6'h01;
    end
    xf_t <= xfer_go ? 5'h0f : xf_t - 5'(xf_t != 5'h0);
    div <= div + 3'h1;
    if (div == 3'h7) begin
      sec <= (sec == 5'h15) ? 5'h00 : sec + 5'h01;
    end
  end
  // Pins drop once the pulse is over, never left floating high
  assign pos_done_pin = mv_t != 6'h0 && mv_t < 6'h4 && !mv_bad;
  assign pos_fault_pin = mv_t != 6'h0 && mv_t < 6'h4 && mv_bad;
  assign xfer_done_pin = xf_t != 5'h0 && xf_t < 5'h4;
  assign index_pin = sec == 5'h00 && div < 3'h4;
  assign sector_count_pin = sec;
endmodule : dhos_positioner_model

// *** dhos_head_ctrl_tb_top.sv ***
// Self-checking bench for the head offset and search sequencer
`timescale 1ns/10ps
module dhos_head_ctrl_tb_top import dhos_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [DHOS_AW-1:0] addr = '0;
  logic [DHOS_DW-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic fault_next = 1'b0;
  logic slow = 1'b0;
  logic [DHOS_DW-1:0] rd_data;
  logic pos_done_pin, pos_fault_pin, xfer_done_pin, index_pin;
  logic [DHOS_SEC_W-1:0] sector_count_pin;
  logic pos_go, xfer_go, attention_line, drive_ready_flag, positioning_active;
  dhos_pos_cmd_t pos_cmd;
  dhos_xfer_t xfer_cmd;
  logic [7:0] codes [6] = '{8'h10, 8'h90, 8'h20, 8'ha0, 8'h30, 8'hb0};
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int gos = 0;
  int n = 0;
  always #5 sys_clk = ~sys_clk;
  dhos_head_ctrl #(.RTC_CYCLES(50), .SEEK_CYCLES(80), .RECAL_CYCLES(100)) DUT (.sys_clk,
    .reset_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .pos_done_pin, .pos_fault_pin,
    .xfer_done_pin, .index_pin, .sector_count_pin, .pos_go, .pos_cmd, .xfer_go, .xfer_cmd,
    .attention_line, .drive_ready_flag, .positioning_active);
  dhos_positioner_model u_far (.sys_clk, .pos_go, .xfer_go, .fault_next, .slow,
    .pos_done_pin, .pos_fault_pin, .xfer_done_pin, .index_pin, .sector_count_pin);
  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pos_go === 1'b1) gos <= gos + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic eq(input logic [18:0] got, input logic [18:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : eq
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 eq({3'h0, rd_data & m}, {3'h0, e});
    @(posedge sys_clk);
  endtask : rd
  // Bounded wait: 0 move, 1 transfer, 2 attention, 3 ready, 4 index
  task automatic wt(input int s);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (!(s == 0 ? pos_go : s == 1 ? xfer_go : s == 2 ? attention_line :
      s == 3 ? drive_ready_flag : index_pin) && k < 800);
    eq(19'(k < 800), 19'h1);
  endtask : wt
  task automatic mv(input dhos_kind_t kd, input logic sg, input logic [5:0] mg);
    wt(0);
    eq({pos_cmd.kind, pos_cmd.off_sign, pos_cmd.off_mag}, {kd, sg, mg});
  endtask : mv
  task automatic off(input logic [7:0] c);
    wr(DHOS_REG_OFFSET, {8'h0, c | 8'h40});
    rd(DHOS_REG_OFFSET, {8'h0, c}, 16'hffff);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_OFFSET});
    mv(DHOS_K_OFFSET, c[7], c[5:0]);
    wt(2);
    rd(DHOS_REG_STATUS, 16'h0029, 16'hffff);
    wr(DHOS_REG_STATUS, 16'h0007);
  endtask : off
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(DHOS_REG_STATUS, 16'h0008, 16'hffff);
    rd(3'h7, 16'h0000, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      off(codes[i]);
    end
    n = gos;
    wr(DHOS_REG_SECTRK, 16'h0300);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_READ});
    wt(1);
    eq({xfer_cmd, 8'(gos)}, {11'h060, 8'(n)});
    wt(3);
    rd(DHOS_REG_STATUS, 16'h0028, 16'hffff);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_WRITE});
    mv(DHOS_K_RTC, 1'b0, 6'h00);
    wt(1);
    eq({xfer_cmd.write, attention_line}, 2'b10);
    wt(3);
    rd(DHOS_REG_STATUS, 16'h0008, 16'hffff);
    off(8'ha0);
    wr(DHOS_REG_CYL, 16'h0007);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_SEEK});
    mv(DHOS_K_RTC, 1'b0, 6'h00);
    wt(0);
    eq({pos_cmd.kind, pos_cmd.cyl, attention_line}, {DHOS_K_SEEK, 10'h007, 1'b0});
    wt(2);
    rd(DHOS_REG_OFFSET, 16'h0000, 16'hffff);
    rd(DHOS_REG_CURCYL, 16'h0007, 16'hffff);
    wr(DHOS_REG_STATUS, 16'h0007);
    off(8'h01);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_RECAL});
    mv(DHOS_K_RTC, 1'b0, 6'h00);
    mv(DHOS_K_RECAL, 1'b0, 6'h00);
    wt(2);
    rd(DHOS_REG_CURCYL, 16'h0000, 16'hffff);
    wr(DHOS_REG_STATUS, 16'h0007);
    off(8'h01);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_RTC});
    mv(DHOS_K_RTC, 1'b0, 6'h00);
    eq({positioning_active, drive_ready_flag}, 2'b10);
    n = cyc;
    wt(2);
    eq(19'(cyc - n <= 50), 19'h1);
    rd(DHOS_REG_STATUS, 16'h0009, 16'hffff);
    wr(DHOS_REG_STATUS, 16'h0007);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) off(8'h04);
      else wr(DHOS_REG_OFFSET, 16'h0004);
      fault_next <= 1'b1;
      wr(DHOS_REG_CTRL, {10'h0, (i == 1) ? DHOS_FN_RTC : DHOS_FN_OFFSET});
      wt(0);
      fault_next <= 1'b0;
      mv(DHOS_K_RECAL, 1'b0, 6'h00);
      wt(2);
      rd(DHOS_REG_STATUS, 16'h000b, 16'h001f);
      wr(DHOS_REG_STATUS, 16'h0007);
    end
    wr(DHOS_REG_SECTRK, 16'h0005);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_SEARCH});
    wt(2);
    rd(DHOS_REG_STATUS, 16'h0009, 16'h000f);
    wr(DHOS_REG_STATUS, 16'h0007);
    wr(DHOS_REG_SECTRK, 16'h001f);
    // Start just after an index so both sides count the same two pulses
    wt(4);
    repeat (8) @(posedge sys_clk);
    wr(DHOS_REG_CTRL, {10'h0, DHOS_FN_SEARCH});
    wt(4);
    repeat (4) @(posedge sys_clk);
    rd(DHOS_REG_STATUS, 16'h0000, 16'h0005);
    wt(4);
    repeat (8) @(posedge sys_clk);
    rd(DHOS_REG_STATUS, 16'h000c, 16'h000f);
    report_and_stop;
  end
endmodule : dhos_head_ctrl_tb_top
